// ==== cob_pkg.sv ====
// cob_pkg: command codes, reset values, write masks, field positions and
// setting figures for the charger option control bank.
// assumes a host register engine that hands over decoded word or byte writes.
package cob_pkg;

  // ==========================================================
  // command codes, word access
  localparam logic [7:0]  CMD_OPT0_WORD   = 8'h12;
  localparam logic [7:0]  CMD_OPT1_WORD   = 8'h3B;
  localparam logic [7:0]  CMD_CHGCUR_WORD = 8'h14;

  // ==========================================================
  // command codes, byte access (low byte / high byte)
  localparam logic [7:0]  CMD_OPT0_LO     = 8'h00;
  localparam logic [7:0]  CMD_OPT0_HI     = 8'h01;
  localparam logic [7:0]  CMD_OPT1_LO     = 8'h02;
  localparam logic [7:0]  CMD_OPT1_HI     = 8'h03;
  localparam logic [7:0]  CMD_CHGCUR_LO   = 8'h0A;
  localparam logic [7:0]  CMD_CHGCUR_HI   = 8'h0B;

  // ==========================================================
  // reset values and writable bits
  localparam logic [15:0] OPT0_RST_WORD   = 16'hE14E;  // frequency field 01
  localparam logic [1:0]  FREQ_RST_BYTE   = 2'h3;      // byte-access variant
  localparam logic [15:0] OPT0_WR_MASK    = 16'hFFFB;  // bit 2 read only
  localparam logic [15:0] OPT1_RST        = 16'h0211;
  localparam logic [15:0] OPT1_WR_MASK    = 16'h1EFF;  // 15:13 and 8 read only
  localparam logic [15:0] CHGCUR_RST      = 16'h0000;
  localparam logic [15:0] CHGCUR_WR_MASK  = 16'hFFFF;
  localparam logic [15:0] RD_UNMAPPED     = 16'h0000;

  // ==========================================================
  // field positions in the first option register
  localparam int          OPT0_ACOUSTIC   = 10;
  localparam int          OPT0_FREQ_LSB   = 8;
  localparam int          OPT0_IN_OCTRIP  = 7;
  localparam int          OPT0_LS_OCP     = 6;
  localparam int          OPT0_CAL_DIS    = 5;
  localparam int          OPT0_IN_GAIN    = 4;
  localparam int          OPT0_BAT_GAIN   = 3;
  localparam int          OPT0_IREG_EN    = 1;
  localparam int          OPT0_INHIBIT    = 0;

  // ==========================================================
  // switching frequency codes and values
  localparam logic [1:0]  FREQ_600K       = 2'h0;
  localparam logic [1:0]  FREQ_800K       = 2'h1;
  localparam logic [1:0]  FREQ_1000K      = 2'h2;
  localparam logic [1:0]  FREQ_1200K      = 2'h3;
  localparam logic [11:0] KHZ_600         = 12'h258;
  localparam logic [11:0] KHZ_800         = 12'h320;
  localparam logic [11:0] KHZ_1000        = 12'h3E8;
  localparam logic [11:0] KHZ_1200        = 12'h4B0;
  localparam logic [11:0] KHZ_ACOUSTIC    = 12'h028;   // 40 kHz floor
  localparam logic [11:0] KHZ_NO_FLOOR    = 12'h000;

  // ==========================================================
  // protection and monitor figures
  localparam logic [9:0]  OCTRIP_PCT      = 10'h12C;   // 300 percent
  localparam logic [9:0]  LS_OCP_LO_MV    = 10'h0AA;   // 170 mV
  localparam logic [9:0]  LS_OCP_HI_MV    = 10'h122;   // 290 mV
  localparam logic [6:0]  IN_GAIN_LO      = 7'h28;     // 40x
  localparam logic [6:0]  IN_GAIN_HI      = 7'h50;     // 80x
  localparam logic [6:0]  BAT_GAIN_LO     = 7'h08;     // 8x
  localparam logic [6:0]  BAT_GAIN_HI     = 7'h10;     // 16x

endpackage

// ==== cob_cfg_reg.sv ====
// cob_cfg_reg: one 16-bit option register with low/high byte write strobes,
// a per-bit write mask and a constant reset value.
// assumes strobes and data are on the same clock as the register.
`timescale 1ns/1ns

module cob_cfg_reg #(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hFFFF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // write side
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [15:0] wr_data,
  // stored value
  output logic      [15:0] q
);

  logic [15:0] lane_q;
  logic [15:0] d;

  // byte lanes selected by the strobes
  assign lane_q = {{8{wr_hi}}, {8{wr_lo}}};

  // only writable bits in an enabled lane take new data
  assign d = (q & ~(lane_q & WR_MASK)) | (wr_data & lane_q & WR_MASK);

  // storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

endmodule // cob_cfg_reg

// ==== cob_option_bank.sv ====
// cob_option_bank: option registers of the charge controller and the
// converter controls that they steer.
// assumes a register engine that decodes host transactions into one-cycle
// write and read strobes with a command code; power path requests come from
// logic on the same clock.
`timescale 1ns/1ns

module cob_option_bank #(
  parameter bit BYTE_VARIANT = 1'b0  // 1: byte access and 1.2 MHz default
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_cmd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // power path requests outside calibration mode
  input  wire logic        pp_adapter_req,
  input  wire logic        pp_rblock_req,
  input  wire logic        pp_battery_req,
  // converter and switch controls
  output logic             buck_enable,
  output logic             adapter_switch_on,
  output logic             reverse_block_switch_on,
  output logic             battery_switch_on,
  output logic             charge_enable,
  output logic             input_regulation_enable,
  output logic             calibration_discharge_mode,
  // settings
  output logic      [1:0]  sw_freq_sel,
  output logic      [11:0] sw_freq_khz,
  output logic      [11:0] sw_freq_floor_khz,
  output logic             input_overcurrent_trip_en,
  output logic      [9:0]  input_overcurrent_trip_pct,
  output logic      [9:0]  low_side_switch_ocp_mv,
  output logic      [6:0]  input_current_monitor_gain,
  output logic      [6:0]  battery_current_monitor_gain,
  // raw register contents
  output logic      [15:0] converter_protection_config,
  output logic      [15:0] monitor_comparator_config
);

  // ==========================================================
  // reset release
  logic [1:0]  rst_sync_q;
  logic        rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // command decode
  localparam logic [15:0] OPT0_RST = BYTE_VARIANT ?
    {cob_pkg::OPT0_RST_WORD[15:10], cob_pkg::FREQ_RST_BYTE, cob_pkg::OPT0_RST_WORD[7:0]} :
    cob_pkg::OPT0_RST_WORD;

  logic        opt0_lo;
  logic        opt0_hi;
  logic        opt1_lo;
  logic        opt1_hi;
  logic        chg_lo;
  logic        chg_hi;
  logic [15:0] wdata;
  logic [15:0] chgcur;

  // word codes in word mode, low/high byte codes in byte mode
  always_comb begin
    opt0_lo = 1'b0;
    opt0_hi = 1'b0;
    opt1_lo = 1'b0;
    opt1_hi = 1'b0;
    chg_lo  = 1'b0;
    chg_hi  = 1'b0;
    wdata   = reg_wdata;
    if (reg_wr) begin
      if (!BYTE_VARIANT) begin
        opt0_lo = (reg_cmd == cob_pkg::CMD_OPT0_WORD);
        opt0_hi = opt0_lo;
        opt1_lo = (reg_cmd == cob_pkg::CMD_OPT1_WORD);
        opt1_hi = opt1_lo;
        chg_lo  = (reg_cmd == cob_pkg::CMD_CHGCUR_WORD);
        chg_hi  = chg_lo;
      end else begin
        opt0_lo = (reg_cmd == cob_pkg::CMD_OPT0_LO);
        opt0_hi = (reg_cmd == cob_pkg::CMD_OPT0_HI);
        opt1_lo = (reg_cmd == cob_pkg::CMD_OPT1_LO);
        opt1_hi = (reg_cmd == cob_pkg::CMD_OPT1_HI);
        chg_lo  = (reg_cmd == cob_pkg::CMD_CHGCUR_LO);
        chg_hi  = (reg_cmd == cob_pkg::CMD_CHGCUR_HI);
        wdata   = {reg_wdata[7:0], reg_wdata[7:0]};     // byte on both lanes
      end
    end
  end

  // ==========================================================
  // registers
  // first option register, reset 0xE14E or with 11 frequency code
  cob_cfg_reg #(
    .RST_VAL (OPT0_RST),
    .WR_MASK (cob_pkg::OPT0_WR_MASK)
  ) u_opt0 (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_lo   (opt0_lo),
    .wr_hi   (opt0_hi),
    .wr_data (wdata),
    .q       (converter_protection_config)
  );

  // second option register, layout only
  cob_cfg_reg #(
    .RST_VAL (cob_pkg::OPT1_RST),
    .WR_MASK (cob_pkg::OPT1_WR_MASK)
  ) u_opt1 (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_lo   (opt1_lo),
    .wr_hi   (opt1_hi),
    .wr_data (wdata),
    .q       (monitor_comparator_config)
  );

  // charge current word, zero at reset
  cob_cfg_reg #(
    .RST_VAL (cob_pkg::CHGCUR_RST),
    .WR_MASK (cob_pkg::CHGCUR_WR_MASK)
  ) u_chgcur (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_lo   (chg_lo),
    .wr_hi   (chg_hi),
    .wr_data (wdata),
    .q       (chgcur)
  );

  // ==========================================================
  // read path
  logic [15:0] rd_d;

  // select word, or the addressed byte in byte mode
  always_comb begin
    rd_d = cob_pkg::RD_UNMAPPED;
    if (!BYTE_VARIANT) begin
      case (reg_cmd)
        cob_pkg::CMD_OPT0_WORD:   rd_d = converter_protection_config;
        cob_pkg::CMD_OPT1_WORD:   rd_d = monitor_comparator_config;
        cob_pkg::CMD_CHGCUR_WORD: rd_d = chgcur;
        default:                  rd_d = cob_pkg::RD_UNMAPPED;
      endcase
    end else begin
      case (reg_cmd)
        cob_pkg::CMD_OPT0_LO:   rd_d = {8'h00, converter_protection_config[7:0]};
        cob_pkg::CMD_OPT0_HI:   rd_d = {8'h00, converter_protection_config[15:8]};
        cob_pkg::CMD_OPT1_LO:   rd_d = {8'h00, monitor_comparator_config[7:0]};
        cob_pkg::CMD_OPT1_HI:   rd_d = {8'h00, monitor_comparator_config[15:8]};
        cob_pkg::CMD_CHGCUR_LO: rd_d = {8'h00, chgcur[7:0]};
        cob_pkg::CMD_CHGCUR_HI: rd_d = {8'h00, chgcur[15:8]};
        default:                rd_d = cob_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= cob_pkg::RD_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_d;
      end
    end
  end

  // ==========================================================
  // field views
  logic       acoustic;
  logic [1:0] freq;
  logic       oc_trip;
  logic       ls_ocp;
  logic       cal_dis;
  logic       in_gain;
  logic       bat_gain;
  logic       ireg_en;
  logic       inhibit;

  assign acoustic = converter_protection_config[cob_pkg::OPT0_ACOUSTIC];
  assign freq     = converter_protection_config[cob_pkg::OPT0_FREQ_LSB +: 2];
  assign oc_trip  = converter_protection_config[cob_pkg::OPT0_IN_OCTRIP];
  assign ls_ocp   = converter_protection_config[cob_pkg::OPT0_LS_OCP];
  assign cal_dis  = converter_protection_config[cob_pkg::OPT0_CAL_DIS];
  assign in_gain  = converter_protection_config[cob_pkg::OPT0_IN_GAIN];
  assign bat_gain = converter_protection_config[cob_pkg::OPT0_BAT_GAIN];
  assign ireg_en  = converter_protection_config[cob_pkg::OPT0_IREG_EN];
  assign inhibit  = converter_protection_config[cob_pkg::OPT0_INHIBIT];

  // ==========================================================
  // converter settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // follow the register's reset frequency code, not a fixed 00
      sw_freq_sel                  <= OPT0_RST[cob_pkg::OPT0_FREQ_LSB +: 2];
      sw_freq_khz                  <= BYTE_VARIANT ? cob_pkg::KHZ_1200 : cob_pkg::KHZ_800;
      sw_freq_floor_khz            <= cob_pkg::KHZ_NO_FLOOR;
      input_overcurrent_trip_en    <= 1'b0;
      input_overcurrent_trip_pct   <= cob_pkg::OCTRIP_PCT;
      low_side_switch_ocp_mv       <= cob_pkg::LS_OCP_HI_MV;
      input_current_monitor_gain   <= cob_pkg::IN_GAIN_LO;
      battery_current_monitor_gain <= cob_pkg::BAT_GAIN_HI;
      input_regulation_enable      <= 1'b1;
    end else begin
      sw_freq_sel <= freq;
      case (freq)
        cob_pkg::FREQ_600K:  sw_freq_khz <= cob_pkg::KHZ_600;
        cob_pkg::FREQ_800K:  sw_freq_khz <= cob_pkg::KHZ_800;
        cob_pkg::FREQ_1000K: sw_freq_khz <= cob_pkg::KHZ_1000;
        cob_pkg::FREQ_1200K: sw_freq_khz <= cob_pkg::KHZ_1200;
        default:             sw_freq_khz <= cob_pkg::KHZ_800;
      endcase
      sw_freq_floor_khz <= acoustic ? cob_pkg::KHZ_ACOUSTIC : cob_pkg::KHZ_NO_FLOOR;
      input_overcurrent_trip_en  <= oc_trip;
      input_overcurrent_trip_pct <= cob_pkg::OCTRIP_PCT;
      low_side_switch_ocp_mv <= ls_ocp ? cob_pkg::LS_OCP_HI_MV : cob_pkg::LS_OCP_LO_MV;
      input_current_monitor_gain <= in_gain ? cob_pkg::IN_GAIN_HI : cob_pkg::IN_GAIN_LO;
      battery_current_monitor_gain <= bat_gain ? cob_pkg::BAT_GAIN_HI : cob_pkg::BAT_GAIN_LO;
      input_regulation_enable <= ireg_en;
    end
  end

  // ==========================================================
  // power path and charge control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buck_enable                <= 1'b1;
      adapter_switch_on          <= 1'b0;
      reverse_block_switch_on    <= 1'b0;
      battery_switch_on          <= 1'b0;
      calibration_discharge_mode <= 1'b0;
      charge_enable              <= 1'b0;
    end else begin
      calibration_discharge_mode <= cal_dis;
      buck_enable                <= ~cal_dis;
      adapter_switch_on          <= cal_dis | pp_adapter_req;
      reverse_block_switch_on    <= cal_dis | pp_rblock_req;
      battery_switch_on          <= cal_dis | pp_battery_req;
      charge_enable              <= ~inhibit & (chgcur != cob_pkg::CHGCUR_RST) & ~cal_dis;
    end
  end

endmodule // cob_option_bank

// ==== cob_option_bank_monitor.sv ====
// cob_option_bank_monitor: concurrent checks on the option bank outputs.
// assumes the port names of cob_option_bank and one clock domain.
`timescale 1ns/1ns

module cob_option_bank_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // register port
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_cmd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  // controls
  input wire logic        buck_enable,
  input wire logic        adapter_switch_on,
  input wire logic        reverse_block_switch_on,
  input wire logic        battery_switch_on,
  input wire logic        charge_enable,
  input wire logic        input_regulation_enable,
  input wire logic        calibration_discharge_mode,
  // settings
  input wire logic [1:0]  sw_freq_sel,
  input wire logic [11:0] sw_freq_khz,
  input wire logic [11:0] sw_freq_floor_khz,
  input wire logic        input_overcurrent_trip_en,
  input wire logic [9:0]  input_overcurrent_trip_pct,
  input wire logic [9:0]  low_side_switch_ocp_mv,
  input wire logic [6:0]  input_current_monitor_gain,
  input wire logic [6:0]  battery_current_monitor_gain,
  input wire logic [15:0] converter_protection_config
);
  // ==========================================================
  // settle counter, hides the two-flop reset release
  logic [2:0] up_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || up_q != 3'h7);

  // ==========================================================
  // field to output relations and register read timing
  chk_cal_paths: assert property (
    calibration_discharge_mode |-> !buck_enable && adapter_switch_on && reverse_block_switch_on && battery_switch_on)
    else $error("calibration mode path wrong");
  chk_cal_exit: assert property (
    $fell(calibration_discharge_mode) |-> buck_enable) else $error("buck not restarted");
  chk_freq_map: assert property (
    sw_freq_sel == $past(converter_protection_config[9:8]) && sw_freq_khz == (sw_freq_sel == 2'h0 ? 12'h258 :
    sw_freq_sel == 2'h1 ? 12'h320 : sw_freq_sel == 2'h2 ? 12'h3E8 : 12'h4B0)) else $error("frequency wrong");
  chk_freq_floor: assert property (
    sw_freq_floor_khz == ($past(converter_protection_config[10]) ? 12'h028 : 12'h000)) else $error("floor wrong");
  chk_trip_arm: assert property (
    input_overcurrent_trip_en == $past(converter_protection_config[7]) && input_overcurrent_trip_pct == 10'h12C)
    else $error("trip wrong");
  chk_ls_ocp: assert property (
    low_side_switch_ocp_mv == ($past(converter_protection_config[6]) ? 10'h122 : 10'h0AA)) else $error("ocp wrong");
  chk_in_gain: assert property (
    input_current_monitor_gain == ($past(converter_protection_config[4]) ? 7'h50 : 7'h28)) else $error("in gain");
  chk_bat_gain: assert property (
    battery_current_monitor_gain == ($past(converter_protection_config[3]) ? 7'h10 : 7'h08)) else $error("bat gain");
  chk_ireg_en: assert property (
    input_regulation_enable == $past(converter_protection_config[1])) else $error("regulation enable wrong");
  chk_inhibit_block: assert property (
    $past(converter_protection_config[0]) |-> !charge_enable) else $error("charge not inhibited");
  chk_read_pulse: assert property (
    reg_rvalid == $past(reg_rd)) else $error("read valid timing wrong");
  chk_opt0_read: assert property (
    reg_rd && reg_cmd == 8'h12 |=> reg_rdata == $past(converter_protection_config)) else $error("read data wrong");
endmodule // cob_option_bank_monitor

bind cob_option_bank cob_option_bank_monitor u_mon (.clk, .rstn, .reg_rd, .reg_cmd, .reg_rdata, .reg_rvalid,
  .buck_enable, .adapter_switch_on, .reverse_block_switch_on, .battery_switch_on, .charge_enable,
  .input_regulation_enable, .calibration_discharge_mode, .sw_freq_sel, .sw_freq_khz, .sw_freq_floor_khz,
  .input_overcurrent_trip_en, .input_overcurrent_trip_pct, .low_side_switch_ocp_mv, .input_current_monitor_gain,
  .battery_current_monitor_gain, .converter_protection_config);

// ==== cob_host_model.sv ====
// cob_host_model: host side of the register port, one-cycle strobes.
// assumes requests are launched on the falling clock edge.
`timescale 1ns/1ns

module cob_host_model (
  // clock
  input  wire logic        clk,
  // request side
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_cmd,
  output logic      [15:0] reg_wdata,
  // answer side
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // ==========================================================
  // idle values at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
  end

  // one write, lines left inverted once released
  task automatic host_write(input logic [7:0] cmd, input logic [15:0] d);
    @(negedge clk);
    reg_cmd = cmd;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_cmd = ~cmd;
    reg_wdata = ~d;
  endtask

  // one read, answer taken while valid stands
  task automatic host_read(input logic [7:0] cmd, output logic [15:0] d, output logic v);
    @(negedge clk);
    reg_cmd = cmd;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_cmd = ~cmd;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // cob_host_model

// ==== cob_option_bank_bench.sv ====
// cob_option_bank_bench: self-checking bench for the option bank.
// assumes the word-access variant and the host model beside it.
`timescale 1ns/1ns

module cob_option_bank_bench;
  // ==========================================================
  // signals
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        pp_adapter_req = 1'b0, pp_rblock_req = 1'b0, pp_battery_req = 1'b0;
  logic        reg_wr, reg_rd, reg_rvalid, buck_enable, adapter_switch_on, reverse_block_switch_on;
  logic        battery_switch_on, charge_enable, input_regulation_enable, calibration_discharge_mode;
  logic        input_overcurrent_trip_en;
  logic [1:0]  sw_freq_sel;
  logic [6:0]  input_current_monitor_gain, battery_current_monitor_gain;
  logic [7:0]  reg_cmd;
  logic [9:0]  input_overcurrent_trip_pct, low_side_switch_ocp_mv;
  logic [11:0] sw_freq_khz, sw_freq_floor_khz;
  logic [15:0] reg_wdata, reg_rdata, converter_protection_config, monitor_comparator_config;
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #2 clk = ~clk;

  cob_option_bank uut (.clk, .rstn, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .pp_adapter_req, .pp_rblock_req, .pp_battery_req, .buck_enable, .adapter_switch_on, .reverse_block_switch_on,
    .battery_switch_on, .charge_enable, .input_regulation_enable, .calibration_discharge_mode, .sw_freq_sel,
    .sw_freq_khz, .sw_freq_floor_khz, .input_overcurrent_trip_en, .input_overcurrent_trip_pct,
    .low_side_switch_ocp_mv, .input_current_monitor_gain, .battery_current_monitor_gain,
    .converter_protection_config, .monitor_comparator_config);
  cob_host_model host (.clk, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata, .reg_rdata, .reg_rvalid);

  // ==========================================================
  // shared tasks
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    host.host_write(cmd, d);
    repeat (3) @(negedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.host_read(cmd, d, v);
    check(nm, d, exp);
    check("rvalid", 16'(v), 16'h0001);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdchk("opt0", 8'h12, 16'hE14E);
    rdchk("opt1", 8'h3B, 16'h0211);
    rdchk("unmapped", 8'h77, 16'h0000);
    check("sel", 16'(sw_freq_sel), 16'h0001);
    check("khz", 16'(sw_freq_khz), 16'h0320);
    check("floor", 16'(sw_freq_floor_khz), 16'h0000);
    check("trip", 16'(input_overcurrent_trip_en), 16'h0000);
    check("ocp", 16'(low_side_switch_ocp_mv), 16'h0122);
    check("ingain", 16'(input_current_monitor_gain), 16'h0028);
    check("batgain", 16'(battery_current_monitor_gain), 16'h0010);
    check("ireg", 16'(input_regulation_enable), 16'h0001);
    check("cal", 16'(calibration_discharge_mode), 16'h0000);
    check("charge", 16'(charge_enable), 16'h0000);
  endtask

  task automatic t_freq();
    logic [11:0] tab [4] = '{12'h258, 12'h320, 12'h3E8, 12'h4B0};
    for (int i = 0; i < 4; i++) begin
      wr(8'h12, 16'hE04E | 16'(i << 8) | 16'(i % 2 << 10));
      check("khz", 16'(sw_freq_khz), 16'(tab[i]));
      check("sel", 16'(sw_freq_sel), 16'(i));
      check("floor", 16'(sw_freq_floor_khz), i % 2 ? 16'h0028 : 16'h0000);
    end
  endtask

  task automatic t_fields();
    wr(8'h12, 16'hE190);
    rdchk("opt0", 8'h12, 16'hE194);
    check("trip", 16'(input_overcurrent_trip_en), 16'h0001);
    check("pct", 16'(input_overcurrent_trip_pct), 16'h012C);
    check("ocp", 16'(low_side_switch_ocp_mv), 16'h00AA);
    check("ingain", 16'(input_current_monitor_gain), 16'h0050);
    check("batgain", 16'(battery_current_monitor_gain), 16'h0008);
    check("ireg", 16'(input_regulation_enable), 16'h0000);
  endtask

  task automatic t_cal();
    wr(8'h12, 16'hE16E);
    check("buck", 16'(buck_enable), 16'h0000);
    check("paths", 16'({adapter_switch_on, reverse_block_switch_on, battery_switch_on}), 16'h0007);
    wr(8'h12, 16'hE14E);
    check("buck", 16'(buck_enable), 16'h0001);
    check("cal", 16'(calibration_discharge_mode), 16'h0000);
    check("paths", 16'({adapter_switch_on, reverse_block_switch_on, battery_switch_on}), 16'h0000);
    // outside calibration the switches follow the power path requests
    pp_battery_req = 1'b1;
    repeat (2) @(negedge clk);
    check("paths", 16'({adapter_switch_on, reverse_block_switch_on, battery_switch_on}), 16'h0001);
    pp_battery_req = 1'b0;
  endtask

  task automatic t_charge();
    wr(8'h14, 16'h0000);
    wr(8'h12, 16'hE14E);
    check("charge", 16'(charge_enable), 16'h0000);
    wr(8'h14, 16'h0400);
    check("charge", 16'(charge_enable), 16'h0001);
    rdchk("chgcur", 8'h14, 16'h0400);
    wr(8'h12, 16'hE14F);
    check("charge", 16'(charge_enable), 16'h0000);
  endtask

  // mid-run reset restores the defaults and drops charging
  task automatic t_rerst();
    wr(8'h12, 16'h0000);
    rdchk("opt0", 8'h12, 16'h0004);
    wr(8'h14, 16'h0400);
    check("charge", 16'(charge_enable), 16'h0001);
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    check("opt0", converter_protection_config, 16'hE14E);
    check("buck", 16'(buck_enable), 16'h0001);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    rdchk("chgcur", 8'h14, 16'h0000);
    check("charge", 16'(charge_enable), 16'h0000);
    check("ireg", 16'(input_regulation_enable), 16'h0001);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_freq();
    t_fields();
    t_cal();
    t_charge();
    t_rerst();
    end_of_test();
  end

  initial begin
    #40000;
    error_cnt++;
    end_of_test();
  end
endmodule // cob_option_bank_bench
